// File: src/lcr_pkg.sv
// Shared constants for the LED source, resource mirror and duplex register block.
// Assumes a 100 MHz APB clock and 32-bit APB data with 16-bit registers in the low half.
`default_nettype none

package lcr_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] LED_SEL_OFFSET   = 12'h000;
  localparam logic [11:0] RES_MIRR_OFFSET  = 12'h004;
  localparam logic [11:0] DUPLEX_OFFSET    = 12'h008;

  // ----------------------------------------------------------------
  // LED source select fields
  // ----------------------------------------------------------------
  localparam int LED_RAW_BIT      = 15;
  localparam int LED_WAKE_BIT     = 8;
  localparam int LED_PSE_BIT      = 7;
  localparam int LED_ADDRM_BIT    = 5;
  localparam int LED_TX_BIT       = 4;
  localparam int LED_POL_BIT      = 3;
  localparam int LED_RX_BIT       = 2;
  localparam int LED_COL_BIT      = 0;
  // Writable bits; all others read as zero except the raw state bit
  localparam logic [15:0] LED_WR_MASK    = 16'h01bd;
  localparam logic [15:0] LED_SEL_RESET  = 16'h0090;

  // ----------------------------------------------------------------
  // Resource mirror fields
  // ----------------------------------------------------------------
  localparam int MIRR_SHMEM_LSB   = 12;
  localparam int MIRR_BOOT_LSB    = 8;
  localparam int MIRR_IRQ_LSB     = 4;
  localparam int MIRR_INACT_BIT   = 3;
  localparam int MIRR_DMA_LSB     = 0;

  // ----------------------------------------------------------------
  // Duplex config fields
  // ----------------------------------------------------------------
  localparam int DUP_MASTER_BIT   = 0;
  localparam int DUP_AUI_BIT      = 1;
  localparam logic [15:0] DUPLEX_RESET   = 16'h0000;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS      = 10;
  localparam int unsigned LED_STRETCH_NS     = 50000000;
  localparam int unsigned LED_STRETCH_CYCLES = LED_STRETCH_NS / CLK_PERIOD_NS;
  localparam int          STRETCH_CNT_W      = 24;

  // Register selector
  typedef enum logic [1:0] {
    LCR_SEL_LED,
    LCR_SEL_MIRR,
    LCR_SEL_DUP,
    LCR_SEL_NONE
  } lcr_sel_t;

endpackage

`default_nettype wire

// File: src/lcr_led_stretch.sv
// LED pulse stretcher: holds the pin on for a minimum time after each activity.
// Assumes the activity level is synchronous to clk.
`timescale 1ns/1ps
`default_nettype none

module lcr_led_stretch #(
  parameter int unsigned STRETCH_CYCLES = lcr_pkg::LED_STRETCH_CYCLES
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic stretch_en,
  input  wire logic level_in,
  output var  logic led_q
);

  localparam logic [lcr_pkg::STRETCH_CNT_W-1:0] LOAD =
    lcr_pkg::STRETCH_CNT_W'(STRETCH_CYCLES - 1);

  logic [lcr_pkg::STRETCH_CNT_W-1:0] cnt_q;

  // ----------------------------------------------------------------
  // Hold counter
  // ----------------------------------------------------------------
  // Reload on every active cycle so the tail is measured from the last edge
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_q <= '0;
    // A tail kept while disabled would relight the pin once enabled
    else if (!stretch_en)
      cnt_q <= '0;
    else if (level_in)
      cnt_q <= LOAD;
    else if (cnt_q != '0)
      cnt_q <= cnt_q - 1'b1;
  end

  // ----------------------------------------------------------------
  // Pin
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      led_q <= 1'b0;
    else
      led_q <= level_in | (stretch_en & (cnt_q != '0));
  end

endmodule

`default_nettype wire

// File: src/lcr_regs.sv
// LED source select, resource mirror and duplex config registers on APB.
// Assumes activity and resource inputs come from logic on pclk; APB master
// follows the usual setup/access protocol.
//
// Summary of operation
// - LED pin is OR of enabled functions
// - Reset enables transmit only, stretcher on
// - Bit 15 reads raw unstretched combined state
// - Reserved LED select bits read zero
// - Wake enable lights LED on wake frame
// - Bit 5 limits receive LED to matches
// - Bit 4 includes transmit activity
// - Bit 3 lights LED while polarity correct
// - Receive enable includes receive activity
// - Bit 0 includes collision activity
// - Mirror bits 15-12 show shared memory size
// - Mirror bits 11-8 show boot memory size
// - Mirror bits 7-4 show interrupt line
// - Mirror bit 3 set when memory inactive
// - Mirror bits 2-0 show DMA channel
// - AUI full duplex needs both enables
// - AUI duplex bit RW, cleared by reset only
// - Master enable clear forces half duplex
`timescale 1ns/1ps
`default_nettype none

module lcr_regs #(
  parameter int unsigned STRETCH_CYCLES = lcr_pkg::LED_STRETCH_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output var  logic [31:0] prdata,
  output var  logic        pslverr,
  input  wire logic        tx_active,
  input  wire logic        rx_active,
  input  wire logic        rx_addr_match,
  input  wire logic        collision,
  input  wire logic        rx_polarity_ok,
  input  wire logic        wake_frame_seen,
  input  wire logic [3:0]  shared_mem_size,
  input  wire logic [3:0]  boot_mem_size,
  input  wire logic [3:0]  irq_line_select,
  input  wire logic        shared_mem_inactive,
  input  wire logic [2:0]  dma_channel_select,
  output logic             activity_led_pin,
  output var  logic        aui_full_duplex,
  output var  logic        tp_full_duplex,
  output var  logic        gpsi_full_duplex
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Used by both the write and the read path
  function automatic lcr_pkg::lcr_sel_t reg_sel(input logic [11:0] addr);
    lcr_pkg::lcr_sel_t s;
    s = lcr_pkg::LCR_SEL_NONE;
    case (addr)
      lcr_pkg::LED_SEL_OFFSET:  s = lcr_pkg::LCR_SEL_LED;
      lcr_pkg::RES_MIRR_OFFSET: s = lcr_pkg::LCR_SEL_MIRR;
      lcr_pkg::DUPLEX_OFFSET:   s = lcr_pkg::LCR_SEL_DUP;
      default:                  s = lcr_pkg::LCR_SEL_NONE;
    endcase
    return s;
  endfunction

  lcr_pkg::lcr_sel_t sel;
  logic              setup_ph;
  logic              wr_acc;
  logic [15:0]       wmask;

  assign sel      = reg_sel(paddr);
  assign setup_ph = psel & ~penable;
  // Zero wait states: every access completes in its first access cycle
  assign pready   = psel & penable;
  assign wr_acc   = psel & penable & pwrite;
  assign wmask    = {{8{pstrb[1]}}, {8{pstrb[0]}}};

  // ----------------------------------------------------------------
  // Stored registers
  // ----------------------------------------------------------------
  logic [15:0] led_sel_q;
  logic [15:0] led_sel_d;
  logic [15:0] duplex_q;
  logic [15:0] duplex_d;

  always_comb
  begin
    led_sel_d = led_sel_q;
    if (wr_acc && sel == lcr_pkg::LCR_SEL_LED)
      led_sel_d = (led_sel_q & ~wmask) | (pwdata[15:0] & wmask);
    // Reserved and read-only bits never store anything
    led_sel_d = led_sel_d & lcr_pkg::LED_WR_MASK;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      led_sel_q <= lcr_pkg::LED_SEL_RESET;
    else
      led_sel_q <= led_sel_d;
  end

  localparam logic [15:0] DUP_MASK =
    (16'h0001 << lcr_pkg::DUP_MASTER_BIT) | (16'h0001 << lcr_pkg::DUP_AUI_BIT);

  always_comb
  begin
    duplex_d = duplex_q;
    if (wr_acc && sel == lcr_pkg::LCR_SEL_DUP)
      duplex_d = (duplex_q & ~wmask) | (pwdata[15:0] & wmask);
    duplex_d = duplex_d & DUP_MASK;
  end

  // Only the reset pin clears these; no read or stop control touches them
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      duplex_q <= lcr_pkg::DUPLEX_RESET;
    else
      duplex_q <= duplex_d;
  end

  // ----------------------------------------------------------------
  // LED function sources
  // ----------------------------------------------------------------
  localparam int NSRC = 5;

  logic [NSRC-1:0] src;
  logic [NSRC-1:0] en;
  logic [NSRC-1:0] gated;
  logic            rx_qual;
  logic            led_raw;

  // Qualifier narrows receive indication to packets for this node
  assign rx_qual = rx_active &
                   (~led_sel_q[lcr_pkg::LED_ADDRM_BIT] | rx_addr_match);

  assign src = {wake_frame_seen, tx_active, rx_polarity_ok, rx_qual, collision};
  assign en  = {led_sel_q[lcr_pkg::LED_WAKE_BIT],
                led_sel_q[lcr_pkg::LED_TX_BIT],
                led_sel_q[lcr_pkg::LED_POL_BIT],
                led_sel_q[lcr_pkg::LED_RX_BIT],
                led_sel_q[lcr_pkg::LED_COL_BIT]};

  genvar g;
  generate
    for (g = 0; g < NSRC; g++)
    begin : g_src
      assign gated[g] = src[g] & en[g];
    end
  endgenerate

  assign led_raw = |gated;

  // ----------------------------------------------------------------
  // Pulse stretcher
  // ----------------------------------------------------------------
  // A short collision or frame would otherwise be invisible on the pin
  lcr_led_stretch #(
    .STRETCH_CYCLES (STRETCH_CYCLES)
  ) u_stretch (
    .clk        (pclk),
    .rst_n      (presetn),
    .stretch_en (led_sel_q[lcr_pkg::LED_PSE_BIT]),
    .level_in   (led_raw),
    .led_q      (activity_led_pin)
  );

  // ----------------------------------------------------------------
  // Resource mirror
  // ----------------------------------------------------------------
  logic [15:0] mirror;

  always_comb
  begin
    mirror = 16'h0000;
    mirror[lcr_pkg::MIRR_SHMEM_LSB +: 4] = shared_mem_size;
    mirror[lcr_pkg::MIRR_BOOT_LSB  +: 4] = boot_mem_size;
    mirror[lcr_pkg::MIRR_IRQ_LSB   +: 4] = irq_line_select;
    mirror[lcr_pkg::MIRR_INACT_BIT]      = shared_mem_inactive;
    mirror[lcr_pkg::MIRR_DMA_LSB   +: 3] = dma_channel_select;
  end

  // ----------------------------------------------------------------
  // Duplex outputs
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      aui_full_duplex  <= 1'b0;
      tp_full_duplex   <= 1'b0;
      gpsi_full_duplex <= 1'b0;
    end
    else
    begin
      aui_full_duplex  <= duplex_q[lcr_pkg::DUP_MASTER_BIT] &
                          duplex_q[lcr_pkg::DUP_AUI_BIT];
      tp_full_duplex   <= duplex_q[lcr_pkg::DUP_MASTER_BIT];
      gpsi_full_duplex <= duplex_q[lcr_pkg::DUP_MASTER_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Read data and error
  // ----------------------------------------------------------------
  // Captured in the setup cycle so the access cycle sees flop outputs
  logic [15:0] rd_mux;

  always_comb
  begin
    case (sel)
      lcr_pkg::LCR_SEL_LED:
      begin
        rd_mux = led_sel_q;
        rd_mux[lcr_pkg::LED_RAW_BIT] = led_raw;
      end
      lcr_pkg::LCR_SEL_MIRR: rd_mux = mirror;
      lcr_pkg::LCR_SEL_DUP:  rd_mux = duplex_q;
      default:               rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (setup_ph && !pwrite)
      prdata <= {16'h0000, rd_mux};
    else if (!psel)
      prdata <= 32'h0000_0000;
  end

  // Unmapped addresses complete with an error and change nothing
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pslverr <= 1'b0;
    else if (setup_ph)
      pslverr <= (sel == lcr_pkg::LCR_SEL_NONE);
    else if (!psel)
      pslverr <= 1'b0;
  end

endmodule

`default_nettype wire

// File: sim/lcr_regs_props.sv
// Checker for the LED source, resource mirror and duplex register block.
// Assumes it is bound to lcr_regs and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none

module lcr_regs_props (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        tx_active,
  input wire logic        rx_active,
  input wire logic        collision,
  input wire logic        rx_polarity_ok,
  input wire logic        wake_frame_seen,
  input wire logic [3:0]  shared_mem_size,
  input wire logic [3:0]  boot_mem_size,
  input wire logic [3:0]  irq_line_select,
  input wire logic        shared_mem_inactive,
  input wire logic [2:0]  dma_channel_select,
  input wire logic        activity_led_pin,
  input wire logic        aui_full_duplex,
  input wire logic        tp_full_duplex,
  input wire logic        gpsi_full_duplex
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic acc = psel & penable;
  wire logic any_src = tx_active | rx_active | collision | rx_polarity_ok | wake_frame_seen;
  wire logic rd_led = acc & ~pwrite & (paddr == 12'h000);

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  // Outputs come from flops one cycle after the register write edge
  sequence s_dup_wr;
    acc && pwrite && paddr == 12'h008;
  endsequence
  sequence s_dup_out;
    ##2 aui_full_duplex == ($past(pwdata[1], 2) & $past(pwdata[0], 2));
  endsequence
  property p_dup_aui;
    s_dup_wr |-> s_dup_out;
  endproperty
  a_dup_aui: assert property (p_dup_aui) else $error("aui duplex output wrong");
  property p_dup_master;
    s_dup_wr |-> ##2 tp_full_duplex == $past(pwdata[0], 2) && gpsi_full_duplex == tp_full_duplex;
  endproperty
  a_dup_master: assert property (p_dup_master) else $error("master duplex wrong");
  property p_aui_half;
    !tp_full_duplex |-> !aui_full_duplex;
  endproperty
  a_aui_half: assert property (p_aui_half) else $error("aui full without master");
  property p_led_resv;
    rd_led |-> prdata[31:16] == 16'h0000 && prdata[14:9] == 6'h00 && !prdata[6] && !prdata[1];
  endproperty
  a_led_resv: assert property (p_led_resv) else $error("reserved led bits set");
  property p_mirror;
    acc && !pwrite && paddr == 12'h004 |-> prdata == {16'h0000, $past(shared_mem_size),
      $past(boot_mem_size), $past(irq_line_select), $past(shared_mem_inactive),
      $past(dma_channel_select)};
  endproperty
  a_mirror: assert property (p_mirror) else $error("mirror mismatch");
  property p_raw;
    rd_led && prdata[15] |-> $past(any_src);
  endproperty
  a_raw: assert property (p_raw) else $error("raw bit without activity");
  property p_led_cause;
    $rose(activity_led_pin) |-> $past(any_src);
  endproperty
  a_led_cause: assert property (p_led_cause) else $error("led rose without activity");
  property p_unmapped;
    acc && paddr > 12'h008 |-> pslverr && prdata == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  property p_aui_reset;
    $rose(presetn) |-> !aui_full_duplex && !tp_full_duplex;
  endproperty
  a_aui_reset: assert property (p_aui_reset) else $error("duplex not cleared by reset");
endmodule

bind lcr_regs lcr_regs_props i_lcr_regs_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr),
  .tx_active(tx_active), .rx_active(rx_active), .collision(collision),
  .rx_polarity_ok(rx_polarity_ok), .wake_frame_seen(wake_frame_seen),
  .shared_mem_size(shared_mem_size), .boot_mem_size(boot_mem_size),
  .irq_line_select(irq_line_select), .shared_mem_inactive(shared_mem_inactive),
  .dma_channel_select(dma_channel_select), .activity_led_pin(activity_led_pin),
  .aui_full_duplex(aui_full_duplex), .tp_full_duplex(tp_full_duplex),
  .gpsi_full_duplex(gpsi_full_duplex)
);

`default_nettype wire

// File: sim/lcr_regs_bench.sv
// Self-checking bench for the LED source, resource mirror and duplex registers.
// Assumes lcr_regs with a short stretch count; the bench is the APB master.
`timescale 1ns/1ps
`default_nettype none

module lcr_regs_bench;
  localparam int unsigned STRETCH = 8;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel, penable, pwrite, rx_addr_match, shared_mem_inactive;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0]  pstrb, shared_mem_size, boot_mem_size, irq_line_select;
  logic [2:0]  dma_channel_select;
  logic [4:0]  src;
  logic [15:0] seed = 16'h39b7;
  logic [15:0] r, en;
  logic        pready, pslverr, activity_led_pin, aui_full_duplex, tp_full_duplex;
  logic        gpsi_full_duplex, err;
  int          bad_count = 0;
  int          samples_checked = 0;

  lcr_regs #(.STRETCH_CYCLES(STRETCH)) i_lcr_regs (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .tx_active(src[0]), .rx_active(src[1]), .collision(src[2]),
    .rx_polarity_ok(src[3]), .wake_frame_seen(src[4]), .rx_addr_match(rx_addr_match),
    .shared_mem_size(shared_mem_size), .boot_mem_size(boot_mem_size),
    .irq_line_select(irq_line_select), .shared_mem_inactive(shared_mem_inactive),
    .dma_channel_select(dma_channel_select), .activity_led_pin(activity_led_pin),
    .aui_full_duplex(aui_full_duplex), .tp_full_duplex(tp_full_duplex),
    .gpsi_full_duplex(gpsi_full_duplex)
  );

  always #5 pclk = ~pclk;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic rnd();
    seed = lfsr(seed);
    r = seed;
  endtask

  function automatic logic led_level(input logic [15:0] e, input logic [4:0] s, input logic m);
    return (e[lcr_pkg::LED_TX_BIT] & s[0]) | (e[lcr_pkg::LED_COL_BIT] & s[2])
      | (e[lcr_pkg::LED_RX_BIT] & s[1] & (~e[lcr_pkg::LED_ADDRM_BIT] | m))
      | (e[lcr_pkg::LED_POL_BIT] & s[3]) | (e[lcr_pkg::LED_WAKE_BIT] & s[4]);
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      bad_count++;
    end
  endtask

  // Called just after a rising edge; the trailing edge keeps strobes from
  // being assigned twice in one time step by back-to-back calls
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic chk_reset();
    apb(1'b0, lcr_pkg::LED_SEL_OFFSET, 32'h0);
    check(q, 32'h0000_0090);
    apb(1'b0, lcr_pkg::DUPLEX_OFFSET, 32'h0);
    check(q, 32'h0000_0000);
    check({aui_full_duplex, tp_full_duplex}, 32'h0);
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    #400000;
    bad_count++;
    end_sim();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, src, rx_addr_match} <= '0;
    {shared_mem_size, boot_mem_size, irq_line_select, shared_mem_inactive} <= '0;
    dma_channel_select <= '0;
    pstrb <= 4'hf;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk_reset();
    for (int i = 0; i < 40; i++)
    begin
      rnd();
      // Stretcher off in this loop so the pin follows the registered level
      en = r & lcr_pkg::LED_WR_MASK & ~16'h0080;
      apb(1'b1, lcr_pkg::LED_SEL_OFFSET, {r, r & ~16'h0080});
      rnd();
      src <= (i < 5) ? 5'h02 : r[4:0];
      rx_addr_match <= (i < 5) ? 1'b0 : r[5];
      repeat (3) @(posedge pclk);
      check(activity_led_pin, led_level(en, src, rx_addr_match));
      apb(1'b0, lcr_pkg::LED_SEL_OFFSET, 32'h0);
      check(q, {16'h0, led_level(en, src, rx_addr_match), en[14:0]});
      {shared_mem_size, boot_mem_size, irq_line_select, shared_mem_inactive} <= r[12:0];
      dma_channel_select <= r[15:13];
      apb(1'b0, lcr_pkg::RES_MIRR_OFFSET, 32'h0);
      check(q, {16'h0, r[12:0], r[15:13]});
      apb(1'b1, lcr_pkg::DUPLEX_OFFSET, {r, r[15:2], i[1:0]});
      apb(1'b0, lcr_pkg::DUPLEX_OFFSET, 32'h0);
      check(q, {30'h0, i[1:0]});
      check({aui_full_duplex, tp_full_duplex, gpsi_full_duplex},
            {i[1] & i[0], i[0], i[0]});
    end
    // Stretch with a one-cycle transmit burst: raw bit must not be stretched
    src <= 5'h00;
    apb(1'b1, lcr_pkg::LED_SEL_OFFSET, 32'h0000_0090);
    src <= 5'h01;
    @(posedge pclk);
    src <= 5'h00;
    @(posedge pclk);
    apb(1'b0, lcr_pkg::LED_SEL_OFFSET, 32'h0);
    check(q, 32'h0000_0090);
    check(activity_led_pin, 1'b1);
    // Pin seen here was launched one edge earlier; tail ends STRETCH edges after the burst
    repeat (STRETCH - 4) @(posedge pclk);
    check(activity_led_pin, 1'b1);
    @(posedge pclk);
    check(activity_led_pin, 1'b0);
    apb(1'b0, 12'h00c, 32'h0);
    check(q, 32'h0);
    check({31'h0, err}, 32'h1);
    apb(1'b1, lcr_pkg::DUPLEX_OFFSET, 32'h0000_0003);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk_reset();
    end_sim();
  end
endmodule

`default_nettype wire
